/* File: src/ext_bus_addr_data_chipsel.sv */
// Purpose: address, data and chip-select pin logic of the external bus
// Assumes: inputs synchronous to clk; extMaster high while another master owns the bus
// Notes:   address pins are a mux of held transfer state, valid with transfer-begin
`default_nettype none
module ext_bus_addr_data_chipsel (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [2:0]       priorityStrapPins,
    input  wire logic             reqValid,
    output logic                  reqReady,
    input  wire logic [27:0]      reqAddr,
    input  wire logic             reqWrite,
    input  wire logic [1:0]       transferSizeCode,
    input  wire logic             reqIack,
    input  wire logic             reqCpuSpace,
    input  wire logic [2:0]       reqIntLevel,
    input  wire logic [31:0]      reqWdata,
    output logic [31:0]           rdData,
    output logic                  rdValid,
    input  wire logic             pinFuncWe,
    input  wire logic [7:0]       pinFuncData,
    output logic [7:0]            pinFunctionSelectReg,
    input  wire logic             csCfgWe,
    input  wire logic [2:0]       csCfgSel,
    input  wire logic [15:0]      csCfgBase,
    input  wire logic [15:0]      csCfgMask,
    input  wire logic [1:0]       csCfgPort,
    input  wire logic             csCfgBurst,
    input  wire logic [3:0]       csCfgWaits,
    input  wire logic             csCfgIntTerm,
    input  wire logic             csCfgEnable,
    input  wire logic             csCfgCpuSpace,
    input  wire logic             defPortWe,
    input  wire logic [1:0]       defPortData,
    output logic [1:0]            defPortSize,
    input  wire logic [1:0][15:0] dramBankBase,
    input  wire logic [1:0][15:0] dramBankMask,
    input  wire logic [1:0]       dramBankEn,
    input  wire logic [1:0][1:0]  dramPortSize,
    input  wire logic [3:0]       dramColBits,
    input  wire logic [3:0]       dramWaits,
    input  wire logic             extMaster,
    input  wire logic [23:0]      addrIn,
    output logic [23:0]           addrOut,
    output logic                  addrOeN,
    input  wire logic [3:0]       muxPinIn,
    output logic [3:0]            muxPinOut,
    output logic [3:0]            muxPinOeN,
    input  wire logic [31:0]      dataIn,
    output logic [31:0]           dataOut,
    output logic                  dataOeN,
    input  wire logic             transferBeginInN,
    output logic                  transferBeginOutN,
    output logic                  transferBeginOeN,
    input  wire logic             transferAckN,
    output logic [3:0]            csN,
    output logic                  rowStrobeN,
    output logic                  colStrobeN
);
    // ------------------------------------------------------------
    // reset release and strap capture
    // ------------------------------------------------------------
    logic [1:0] rstSync_q;
    logic       rstN;
    logic       strapDone_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n) rstSync_q <= 2'h0;
        else        rstSync_q <= {rstSync_q[0], 1'b1};
    end
    assign rstN = rstSync_q[1];

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN) strapDone_q <= 1'b0;
        else       strapDone_q <= 1'b1;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] portBytes(input logic [1:0] port);
        case (port)
            ext_bus_pkg::PORT_8:  portBytes = 5'h1;
            ext_bus_pkg::PORT_16: portBytes = 5'h2;
            default:              portBytes = 5'h4;
        endcase
    endfunction

    function automatic logic [4:0] sizeBytes(input logic [1:0] size);
        case (size)
            ext_bus_pkg::SZ_BYTE: sizeBytes = 5'h1;
            ext_bus_pkg::SZ_WORD: sizeBytes = 5'h2;
            ext_bus_pkg::SZ_LINE: sizeBytes = 5'h10;
            default:              sizeBytes = 5'h4;
        endcase
    endfunction

    function automatic logic regionHit(input logic [27:0] a, input logic [15:0] base,
                                       input logic [15:0] mask);
        regionHit = ((a[27:ext_bus_pkg::REGION_LSB] ^ base) & ~mask) == 16'h0000;
    endfunction

    // active-low lanes, bit 0 is the top byte lane
    function automatic logic [3:0] laneEnN(input logic [1:0] size, input logic [1:0] a,
                                           input logic [1:0] port);
        logic [3:0] on;
        on = 4'h0;
        case (port)
            ext_bus_pkg::PORT_8:  on = 4'h1;
            ext_bus_pkg::PORT_16:
                if (size == ext_bus_pkg::SZ_BYTE) on = a[0] ? 4'h2 : 4'h1;
                else                              on = 4'h3;
            default:
                if (size == ext_bus_pkg::SZ_BYTE)      on = 4'h1 << a;
                else if (size == ext_bus_pkg::SZ_WORD) on = a[1] ? 4'hC : 4'h3;
                else                                   on = 4'hF;
        endcase
        laneEnN = ~on;
    endfunction

    // ------------------------------------------------------------
    // configuration state
    // ------------------------------------------------------------
    logic [7:0]  pinFunc_q;
    logic [15:0] csBase_q  [ext_bus_pkg::NUM_CS];
    logic [15:0] csMask_q  [ext_bus_pkg::NUM_CS];
    logic [1:0]  csPort_q  [ext_bus_pkg::NUM_CS];
    logic [3:0]  csWaits_q [ext_bus_pkg::NUM_CS];
    logic [7:0]  csBurst_q, csIntTerm_q, csEn_q;
    logic        cs1Cpu_q;
    logic [1:0]  defPort_q;
    logic        cfgTouched_q;

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN) pinFunc_q <= ext_bus_pkg::PIN_FUNC_RESET;
        else if (pinFuncWe) pinFunc_q <= pinFuncData;
    end

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            for (int k = 0; k < ext_bus_pkg::NUM_CS; k++)
            begin
                csBase_q[k]  <= ext_bus_pkg::CS0_BOOT_BASE;
                csMask_q[k]  <= ext_bus_pkg::CS0_BOOT_MASK;
                csPort_q[k]  <= ext_bus_pkg::PORT_32;
                csWaits_q[k] <= ext_bus_pkg::CS0_BOOT_WAITS;
            end
            csBurst_q    <= 8'h00;
            csIntTerm_q  <= 8'h00;
            csEn_q       <= 8'h01;
            cs1Cpu_q     <= 1'b0;
            defPort_q    <= ext_bus_pkg::PORT_32;
            cfgTouched_q <= 1'b0;
        end
        else if (!strapDone_q)
        begin
            defPort_q      <= priorityStrapPins[1:0];
            csPort_q[0]    <= priorityStrapPins[1:0];
            csIntTerm_q[0] <= priorityStrapPins[2];
        end
        else
        begin
            if (csCfgWe)
            begin
                csBase_q[csCfgSel]    <= csCfgBase;
                csMask_q[csCfgSel]    <= csCfgMask;
                csPort_q[csCfgSel]    <= csCfgPort;
                csWaits_q[csCfgSel]   <= csCfgWaits;
                csBurst_q[csCfgSel]   <= csCfgBurst;
                csIntTerm_q[csCfgSel] <= csCfgIntTerm;
                csEn_q[csCfgSel]      <= csCfgEnable;
                cfgTouched_q          <= 1'b1;
                if (csCfgSel == 3'h1) cs1Cpu_q <= csCfgCpuSpace;
            end
            if (defPortWe) defPort_q <= defPortData;
        end
    end

    // ------------------------------------------------------------
    // region decode, first enabled chip select wins, then DRAM; CPU space and iack decode to chip select 1 only
    // ------------------------------------------------------------
    logic [27:0] decAddr;
    logic        decCpu, hitCs, hitDram, hitBank;
    logic [2:0]  hitSel;

    always_comb
    begin
        hitCs   = 1'b0;
        hitDram = 1'b0;
        hitBank = 1'b0;
        hitSel  = 3'h0;
        if (decCpu)
        begin
            hitCs  = cs1Cpu_q && csEn_q[1];
            hitSel = 3'h1;
        end
        else
        begin
            for (int k = ext_bus_pkg::NUM_CS - 1; k >= 0; k--)
            begin
                if (csEn_q[k] && regionHit(decAddr, csBase_q[k], csMask_q[k]))
                begin
                    hitCs  = 1'b1;
                    hitSel = 3'(k);
                end
            end
            for (int b = 1; b >= 0; b--)
            begin
                if (!hitCs && dramBankEn[b] && regionHit(decAddr, dramBankBase[b],
                                                         dramBankMask[b]))
                begin
                    hitDram = 1'b1;
                    hitBank = 1'(b);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    ext_bus_pkg::state_type state_q;
    logic [27:0] addr_q;
    logic [31:0] wdata_q;
    logic [1:0]  size_q, port_q;
    logic [2:0]  level_q, csSel_q;
    logic        write_q, iack_q, ext_q, csHit_q, dram_q, burst_q, intTerm_q;
    logic [3:0]  waits_q, waitCnt_q, beatsLeft_q;
    logic        coreStart, extStart, ack, idleNow;
    logic [1:0]  newPort;
    logic [4:0]  stride;

    assign idleNow   = state_q == ext_bus_pkg::ST_IDLE;
    assign reqReady  = idleNow && strapDone_q && !extMaster;
    assign coreStart = reqValid && reqReady;
    assign extStart  = idleNow && strapDone_q && extMaster && !transferBeginInN;
    assign decCpu    = extStart ? 1'b0 : (reqCpuSpace || reqIack);
    assign decAddr   = extStart ? {muxPinIn, addrIn} : reqAddr;
    assign newPort   = hitCs ? csPort_q[hitSel] : hitDram ? dramPortSize[hitBank] : defPort_q;
    assign stride    = portBytes(port_q);
    assign ack       = state_q == ext_bus_pkg::ST_DATA &&
                       (!transferAckN || (intTerm_q && waitCnt_q == 4'h0));

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            state_q <= ext_bus_pkg::ST_IDLE;
            {addr_q, wdata_q, size_q, port_q, level_q, csSel_q} <= '0;
            {write_q, iack_q, ext_q, csHit_q, dram_q, burst_q, intTerm_q} <= '0;
            {waits_q, waitCnt_q, beatsLeft_q} <= '0;
        end
        else
        begin
            case (state_q)
                ext_bus_pkg::ST_IDLE:
                    if (coreStart || extStart)
                    begin
                        addr_q      <= decAddr;
                        wdata_q     <= reqWdata;
                        write_q     <= coreStart && reqWrite;
                        size_q      <= coreStart ? transferSizeCode : ext_bus_pkg::SZ_LONG;
                        iack_q      <= coreStart && reqIack;
                        level_q     <= reqIntLevel;
                        ext_q       <= extStart;
                        csHit_q     <= hitCs;
                        csSel_q     <= hitSel;
                        dram_q      <= hitDram;
                        port_q      <= newPort;
                        burst_q     <= hitCs ? csBurst_q[hitSel] : 1'b1;
                        intTerm_q   <= hitCs ? csIntTerm_q[hitSel] : hitDram;
                        waits_q     <= hitCs ? csWaits_q[hitSel] : dramWaits;
                        waitCnt_q   <= hitCs ? csWaits_q[hitSel] : dramWaits;
                        beatsLeft_q <= extStart ? 4'h0 : 4'(
                            (sizeBytes(transferSizeCode) + portBytes(newPort) - 5'h1)
                            / portBytes(newPort) - 5'h1);
                        state_q     <= extStart ? (hitDram ? ext_bus_pkg::ST_ROW
                                                           : ext_bus_pkg::ST_DATA)
                                                : ext_bus_pkg::ST_START;
                    end
                ext_bus_pkg::ST_START:
                    state_q <= dram_q ? ext_bus_pkg::ST_ROW : ext_bus_pkg::ST_DATA;
                ext_bus_pkg::ST_ROW:
                    state_q <= ext_bus_pkg::ST_COL;
                ext_bus_pkg::ST_COL:
                    state_q <= ext_bus_pkg::ST_DATA;
                ext_bus_pkg::ST_DATA:
                    if (ack)
                    begin
                        waitCnt_q <= waits_q;
                        if (beatsLeft_q == 4'h0)
                            state_q <= ext_bus_pkg::ST_IDLE;
                        else
                        begin
                            beatsLeft_q <= beatsLeft_q - 4'h1;
                            addr_q      <= addr_q + 28'(stride);
                            wdata_q     <= wdata_q << (8 * stride);
                            // non-burst regions re-issue transfer-begin for every beat
                            state_q     <= dram_q ? ext_bus_pkg::ST_COL :
                                           burst_q ? ext_bus_pkg::ST_DATA :
                                                     ext_bus_pkg::ST_START;
                        end
                    end
                    else if (waitCnt_q != 4'h0)
                        waitCnt_q <= waitCnt_q - 4'h1;
                default:
                    state_q <= ext_bus_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read capture
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            rdData  <= 32'h0000_0000;
            rdValid <= 1'b0;
        end
        else
        begin
            if (ack && !write_q) rdData <= dataIn;
            rdValid <= ack && beatsLeft_q == 4'h0 && !ext_q;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    logic [27:0] pinAddr;
    logic [7:0]  csNInt;
    logic [3:0]  weN;
    logic        rowPh, colPh;

    assign rowPh = state_q == ext_bus_pkg::ST_ROW;
    assign colPh = state_q == ext_bus_pkg::ST_COL;
    always_comb
    begin
        if (iack_q)     pinAddr = {ext_bus_pkg::IACK_HIGH, level_q, 2'h0};
        else if (rowPh) pinAddr = addr_q >> dramColBits;
        else if (colPh) pinAddr = addr_q & ~(28'hFFF_FFFF << dramColBits);
        else            pinAddr = addr_q;
    end
    assign addrOut = pinAddr[23:0];
    assign addrOeN = ext_q ? !(rowPh || colPh) : idleNow;
    assign transferBeginOutN = state_q != ext_bus_pkg::ST_START;
    assign transferBeginOeN  = ext_q || idleNow;
    assign dataOut   = wdata_q;
    assign dataOeN   = !(write_q && !idleNow);
    assign rowStrobeN = !rowPh;
    assign colStrobeN = !colPh;
    assign weN = (state_q == ext_bus_pkg::ST_DATA && write_q && !dram_q) ?
                 laneEnN(size_q, addr_q[1:0], port_q) : 4'hF;
    always_comb
    begin
        csNInt = 8'hFF;
        if (!idleNow && csHit_q) csNInt[csSel_q] = 1'b0;
    end
    assign csN = csNInt[3:0];
    assign pinFunctionSelectReg = pinFunc_q;
    assign defPortSize = defPort_q;

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            case (pinFunc_q[2*i +: 2])
                ext_bus_pkg::FN_ADDR:
                begin
                    muxPinOut[i] = pinAddr[24+i];
                    muxPinOeN[i] = addrOeN;
                end
                ext_bus_pkg::FN_CS:
                begin
                    muxPinOut[i] = csNInt[4+i];
                    muxPinOeN[i] = 1'b0;
                end
                default:
                begin
                    muxPinOut[i] = weN[3-i];
                    muxPinOeN[i] = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_iack_addr;
        @(posedge clk) disable iff (!rstN)
        !transferBeginOutN && iack_q |-> addrOut[23:5] == 19'h7_FFFF &&
            addrOut[1:0] == 2'h0 && addrOut[4:2] == level_q;
    endproperty
    a_iack_addr: assert property (p_iack_addr) else $error("iack address wrong");
    property p_we_reset;
        @(posedge clk) disable iff (!rstN)
        !strapDone_q |-> muxPinOeN == 4'h0 && muxPinOut == 4'hF;
    endproperty
    a_we_reset: assert property (p_we_reset) else $error("upper pins not enables");
    property p_ts_addr;
        @(posedge clk) disable iff (!rstN)
        !transferBeginOutN |-> !addrOeN && !transferBeginOeN;
    endproperty
    a_ts_addr: assert property (p_ts_addr) else $error("address not valid with begin");
    property p_burst_step;
        @(posedge clk) disable iff (!rstN)
        ack && beatsLeft_q != 4'h0 && !dram_q |=> addr_q == $past(addr_q) + 28'($past(stride));
    endproperty
    a_burst_step: assert property (p_burst_step) else $error("burst address no step");
    property p_row_col;
        @(posedge clk) disable iff (!rstN)
        !rowStrobeN |-> !addrOeN ##1 (!colStrobeN && !addrOeN);
    endproperty
    a_row_col: assert property (p_row_col) else $error("row not followed by column");
    property p_ext_quiet;
        @(posedge clk) disable iff (!rstN)
        ext_q && !dram_q && !idleNow |-> addrOeN;
    endproperty
    a_ext_quiet: assert property (p_ext_quiet) else $error("outside master address driven");
    property p_capture;
        @(posedge clk) disable iff (!rstN)
        ack && !write_q |=> rdData == $past(dataIn);
    endproperty
    a_capture: assert property (p_capture) else $error("read data not captured");
    property p_write_drive;
        @(posedge clk) disable iff (!rstN)
        $rose(!transferBeginOutN) && write_q |-> !dataOeN [*2];
    endproperty
    a_write_drive: assert property (p_write_drive) else $error("write data not driven");
    property p_boot_only;
        @(posedge clk) disable iff (!rstN)
        !cfgTouched_q |-> csNInt[7:1] == 7'h7F;
    endproperty
    a_boot_only: assert property (p_boot_only) else $error("upper select asserted");
    property p_default_quiet;
        @(posedge clk) disable iff (!rstN)
        !csHit_q |-> csNInt == 8'hFF;
    endproperty
    a_default_quiet: assert property (p_default_quiet) else $error("select on default");
    c_iack: cover property (@(posedge clk) disable iff (!rstN) iack_q && !csN[1]);
    c_slave_dram: cover property (@(posedge clk) disable iff (!rstN) ext_q && !colStrobeN);
    c_burst: cover property (@(posedge clk) disable iff (!rstN) ack && beatsLeft_q == 4'h3);
endmodule
`default_nettype wire

/* File: src/ext_bus_pkg.sv */
// Purpose: constants of the external bus pin logic
// Assumes: one clock, straps stable around reset release
// Notes:   port code 00 = 32 bit, 01 = 8 bit, 10 = 16 bit
`default_nettype none
package ext_bus_pkg;
    localparam logic [1:0] PORT_32   = 2'h0;
    localparam logic [1:0] PORT_8    = 2'h1;
    localparam logic [1:0] PORT_16   = 2'h2;
    localparam logic [1:0] SZ_LONG   = 2'h0;
    localparam logic [1:0] SZ_BYTE   = 2'h1;
    localparam logic [1:0] SZ_WORD   = 2'h2;
    localparam logic [1:0] SZ_LINE   = 2'h3;
    localparam logic [1:0] FN_WE     = 2'h0;
    localparam logic [1:0] FN_CS     = 2'h1;
    localparam logic [1:0] FN_ADDR   = 2'h2;
    localparam logic [7:0] PIN_FUNC_RESET = 8'h00;
    localparam int         NUM_CS    = 8;
    localparam int         REGION_LSB = 12;
    localparam logic [15:0] CS0_BOOT_BASE = 16'h0000;
    localparam logic [15:0] CS0_BOOT_MASK = 16'hFFFF;
    localparam logic [3:0]  CS0_BOOT_WAITS = 4'hF;
    localparam logic [22:0] IACK_HIGH = 23'h7F_FFFF;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_START = 3'h1,
        ST_ROW   = 3'h3,
        ST_COL   = 3'h2,
        ST_DATA  = 3'h6
    } state_type;
endpackage
`default_nettype wire

/* File: testbench/ext_bus_far_side.sv */
// Purpose: far-side memory of the external bus
// Assumes: while ackEn, ack from the cycle after transfer-begin until address release
// Notes:   idle bus shows the inverse so a stale capture fails
`default_nettype none
module ext_bus_far_side (
    input  wire logic        clk,
    input  wire logic        ackEn,
    input  wire logic        transferBeginOutN,
    input  wire logic [23:0] addrOut,
    input  wire logic        addrOeN,
    input  wire logic        dataOeN,
    output logic             transferAckN,
    output logic [31:0]      dataIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // ack holds through a burst, where no new transfer-begin is given
    always_ff @(posedge clk)
        transferAckN <= ~(ackEn & (~transferBeginOutN | (~transferAckN & ~addrOeN)));
    assign dataIn = (!addrOeN && dataOeN) ? {8'hA5, addrOut} : ~{8'hA5, addrOut};
endmodule
`default_nettype wire

/* File: testbench/ext_bus_addr_data_chipsel_bench.sv */
// Purpose: self-checking bench of the external bus pins
// Assumes: straps give a 32-bit internally ended boot select
// Notes:   DRAM bank 0 is used only by the outside master
`default_nettype none
module ext_bus_addr_data_chipsel_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n, reqValid, reqReady, reqWrite, reqIack, reqCpuSpace, rdValid, pinFuncWe, ackEn;
    logic csCfgWe, csCfgBurst, csCfgIntTerm, csCfgEnable, csCfgCpuSpace, defPortWe, extMaster;
    logic addrOeN, dataOeN, transferBeginInN, transferBeginOutN, transferBeginOeN;
    logic transferAckN, rowStrobeN, colStrobeN;
    logic [2:0] priorityStrapPins, reqIntLevel, csCfgSel;
    logic [1:0] transferSizeCode, csCfgPort, defPortData, defPortSize, dramBankEn;
    logic [3:0] csCfgWaits, dramColBits, dramWaits, muxPinIn, muxPinOut, muxPinOeN, csN;
    logic [7:0] pinFuncData, pinFunctionSelectReg;
    logic [15:0] csCfgBase, csCfgMask;
    logic [1:0][15:0] dramBankBase, dramBankMask;
    logic [1:0][1:0] dramPortSize;
    logic [23:0] addrIn, addrOut;
    logic [27:0] reqAddr;
    logic [31:0] reqWdata, rdData, dataIn, dataOut;
    int num_errors, tests_run;
    ext_bus_addr_data_chipsel DUT (.*);
    ext_bus_far_side far (.*);
    initial forever #50 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cfg(input logic [2:0] s, input logic [15:0] b);
        @(negedge clk);
        {csCfgSel, csCfgBase, csCfgWe} = {s, b, 1'b1};
        @(negedge clk);
        csCfgWe = 0;
    endtask
    task automatic xfer(input logic [27:0] a, input logic w, i, input logic [23:0] ea,
                        input logic [3:0] ecs);
        @(negedge clk);
        {reqAddr, reqWrite, reqIack, reqCpuSpace, reqValid} = {a, w, i, i, 1'b1};
        @(negedge clk);
        reqValid = 0;
        chk({transferBeginOutN, transferBeginOeN, reqReady}, 0, "begin");
        chk(addrOut, ea, "address");
        chk(csN, ecs, "select");
        chk(dataOeN, !w, "data drive");
        if (w)
            chk(dataOut, reqWdata, "write data");
        if (pinFunctionSelectReg === 8'h9A)
            chk({muxPinOeN, muxPinOut}, {4'h0, a[27], 1'b1, a[25:24]}, "upper pins");
        for (int n = 0; n < 40 && rdValid !== 1; n++)
            @(negedge clk);
        chk(rdValid, 1, "done");
        if (!w)
            chk(rdData, {8'hA5, ea}, "read data");
    endtask
    initial
    begin
        {reqValid, pinFuncWe, csCfgWe, defPortWe, extMaster, ackEn, csCfgBurst, rst_n} = '0;
        {reqWrite, reqIack, reqCpuSpace, muxPinIn, pinFuncData, defPortData, reqAddr} = '0;
        {dramBankBase, dramBankMask, dramBankEn, dramPortSize, dramColBits, dramWaits} = '0;
        {csCfgSel, csCfgBase, csCfgMask, csCfgPort, csCfgWaits, addrIn, transferSizeCode} = '0;
        {csCfgIntTerm, csCfgEnable, csCfgCpuSpace, transferBeginInN} = 4'hF;
        {reqIntLevel, reqWdata, priorityStrapPins} = {3'h5, 32'h1234_5678, 3'h4};
        repeat (8) @(negedge clk);
        rst_n = 1;
        repeat (6) @(negedge clk);
        chk(csN, 4'hF, "selects idle");
        chk({muxPinOeN, muxPinOut}, 8'h0F, "write enables");
        chk(pinFunctionSelectReg, ext_bus_pkg::PIN_FUNC_RESET, "pin function");
        chk(defPortSize, ext_bus_pkg::PORT_32, "default port");
        xfer(28'h000_0100, 0, 0, 24'h00_0100, 4'hE);
        $display("reset and boot test done");
        ackEn = 1;
        cfg(3'h0, 16'h0100);
        cfg(3'h1, 16'h0F00);
        cfg(3'h2, 16'h0200);
        xfer(28'h010_0040, 0, 0, 24'h10_0040, 4'hE);
        xfer(28'h020_0008, 1, 0, 24'h20_0008, 4'hB);
        xfer(28'h030_0000, 0, 0, 24'h30_0000, 4'hF);
        xfer(28'h000_0000, 0, 1, 24'hFF_FFF4, 4'hD);
        @(negedge clk);
        {defPortData, defPortWe} = {ext_bus_pkg::PORT_16, 1'b1};
        @(negedge clk);
        defPortWe = 0;
        chk(defPortSize, ext_bus_pkg::PORT_16, "default port");
        {reqAddr, reqWrite, reqIack, reqCpuSpace, reqValid} = {28'h030_0000, 4'h9};
        @(negedge clk);
        reqValid = 0;
        @(negedge clk);
        for (int n = 0; n < 2; n++)
        begin
            chk(addrOut, 24'h30_0000 + 24'(2 * n), "burst address");
            chk(dataOut, n ? 32'h5678_0000 : 32'h1234_5678, "burst data");
            chk({muxPinOeN, muxPinOut}, 8'h03, "write enables");
            @(negedge clk);
        end
        chk(rdValid, 1, "burst done");
        {defPortData, defPortWe} = {ext_bus_pkg::PORT_32, 1'b1};
        @(negedge clk);
        defPortWe = 0;
        $display("chip select test done");
        @(negedge clk);
        {pinFuncData, pinFuncWe} = {8'h9A, 1'b1};
        @(negedge clk);
        pinFuncWe = 0;
        xfer(28'hA30_0000, 0, 0, 24'h30_0000, 4'hF);
        @(negedge clk);
        {extMaster, addrIn, transferBeginInN} = {1'b1, 24'h20_0010, 1'b0};
        @(negedge clk);
        transferBeginInN = 1;
        chk({addrOeN, transferBeginOeN, csN}, 6'h3B, "outside master");
        repeat (4) @(negedge clk);
        {dramBankEn, dramColBits, addrIn, transferBeginInN} = {2'h1, 4'h8, 24'h40_0234, 1'b0};
        dramBankBase[0] = 16'h0400;
        @(negedge clk);
        transferBeginInN = 1;
        chk({csN, rowStrobeN, colStrobeN, addrOeN, addrOut}, {7'h7A, 24'h00_4002}, "row");
        @(negedge clk);
        chk({csN, rowStrobeN, colStrobeN, addrOeN, addrOut}, {7'h7C, 24'h00_0034}, "col");
        repeat (2) @(negedge clk);
        extMaster = 0;
        $display("pin function test done");
        wrap_up();
    end
    initial
    begin
        #400000;
        num_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
